// ---- include/msg_codec_pkg.sv ----
// Package with header layout, flag positions and constants of the binary message codec
package msg_codec_pkg;
  localparam int HDR_LEN = 44;
  localparam int CSUM_LEN = 16;
  localparam int FOOT_LEN = 4;
  localparam int TAIL_LEN = 20;
  localparam int IMM_MAX = 16;
  localparam int OFS_START = 0;
  localparam int OFS_VER = 2;
  localparam int OFS_FLAGS = 4;
  localparam int OFS_ERR = 6;
  localparam int OFS_TYPE = 8;
  localparam int OFS_TAG = 12;
  localparam int OFS_RSVD = 16;
  localparam int OFS_CSUM_TYPE = 22;
  localparam int OFS_IMM_LEN = 23;
  localparam int OFS_IMM = 24;
  localparam int OFS_REMAIN = 40;
  localparam logic [7:0] START_B0 = 8'hc1;
  localparam logic [7:0] START_B1 = 8'hc0;
  localparam logic [31:0] FOOTER = 32'hc5c4c3c2;
  localparam logic [15:0] PROTO_VER_RST = 16'h1100;
  localparam int FLAG_RESP = 0;
  localparam int FLAG_ACK = 1;
  localparam int FLAG_ACK_REQ = 2;
  localparam int FLAG_NACK = 3;
  localparam int FLAG_EXC = 4;
  localparam int FLAG_VER_DEPR = 5;
  localparam int FLAG_TYPE_DEPR = 6;
  localparam logic [7:0] CSUM_NONE = 8'h00;
  localparam logic [7:0] CSUM_MD5 = 8'h01;
  localparam logic [15:0] ERR_FW_DECRYPT = 16'h0064;
  localparam logic [31:0] MAX_REMAIN = 32'h00010000;
endpackage : msg_codec_pkg

// ---- design/byte_field.sv ----
// Little-endian field byte selector, used only by the transmit header build
`timescale 1ns/1ns
module byte_field #(
  parameter int OFS = 0,
  parameter int LEN = 4
) (
  input wire logic [5:0] idx, // Header byte index
  input wire logic [31:0] value, // Field value to serialise
  output logic hit, // Index falls in this field
  output logic [7:0] sel_byte, // Byte of the field at idx
  output logic [1:0] lane // Byte lane within the field
);
  wire [5:0] rel = idx - 6'(OFS);
  assign hit = (idx >= 6'(OFS)) && (idx < 6'(OFS + LEN));
  assign lane = rel[1:0];
  assign sel_byte = value[8*lane +: 8];
endmodule : byte_field

// ---- design/msg_host_codec.sv ----
// Host-side builder and checker of the fixed binary message header and trailer
`timescale 1ns/1ns
// Operation
// R1: Multi-byte header fields go out and come in least significant byte first.
// R2: Every message opens with start bytes c1 c0 at header byte zero.
// R3: Every message closes with footer c5c4c3c2 after the sixteen-byte checksum block.
// R4: Device flags NACK for unknown type and echoes the offending type.
// R5: Device may flag deprecated protocol version in bit five.
// R6: Device may flag deprecated message type in bit six.
// R7: Error number at offset six is non-zero only with NACK or exception.
// R8: Exactly one error code is reported per request.
// R9: Device distinguishes thirteen application error causes.
// R10: Firmware decryption failure reports code one hundred; others for layout, revision.
// R11: Host places four-byte message type at offset eight.
// R12: Host tag at offset twelve is echoed unchanged by the device.
// R13: Checksum type at twenty-two: none or MD5; block always sixteen bytes.
// R14: With MD5 the digest fills the whole sixteen-byte block.
// R15: Immediate length at twenty-three never exceeds sixteen.
// R16: Immediate data at twenty-four; when used, length set and no payload.
// R17: With a payload present the immediate area is ignored.
// R18: Bytes-remaining at forty equals payload plus checksum and footer lengths.
// R19: Payload length is bytes-remaining minus twenty.
// R20: Read fixed header first, then exactly the announced remaining bytes.
// R21: Device may NACK messages too long for its capacity.
// R22: Payload is interpreted by the layout of the message type.
// R23: Six reserved bytes at sixteen are sent as zero and ignored.
module msg_host_codec (
  input wire logic core_clk, // 20 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  // Command side
  input wire logic cmd_valid, // Request to send one message
  output logic cmd_ready, // Transmitter idle
  input wire logic [31:0] cmd_type, // Message type
  input wire logic [31:0] cmd_tag, // Correlation tag
  input wire logic cmd_ack_req, // Ask for acknowledgement
  input wire logic cmd_md5, // Select MD5 checksum type
  input wire logic [4:0] cmd_imm_len, // Immediate byte count
  input wire logic [127:0] cmd_imm, // Immediate data, byte 0 in low bits
  input wire logic [31:0] cmd_pay_len, // Payload length in bytes
  input wire logic [7:0] pay_byte, // Payload byte from user
  output logic pay_take, // Payload byte consumed this cycle
  input wire logic [127:0] csum_blk, // Checksum block, byte 0 in low bits
  output logic cmd_err, // Pulse: request refused as malformed
  // Transmit byte stream
  output logic tx_valid, // Byte valid
  input wire logic tx_ready, // Link takes byte
  output logic [7:0] tx_data, // Byte
  // Receive byte stream
  input wire logic rx_valid, // Byte valid
  output logic rx_ready, // Always accepting
  input wire logic [7:0] rx_data, // Byte
  // Response results
  output logic rsp_done, // Pulse: response fully checked
  output logic [15:0] rsp_flags, // Response flags
  output logic [15:0] rsp_err, // Response error number
  output logic [31:0] rsp_type, // Response message type
  output logic [31:0] rsp_tag, // Response tag
  output logic [31:0] rsp_pay_len, // Derived payload length
  output logic [4:0] rsp_imm_len, // Immediate byte count
  output logic [127:0] rsp_imm, // Immediate data, zero when payload present
  output logic rsp_nack, // Device refused the request
  output logic rsp_exc, // Device exception
  output logic rsp_ver_depr, // Protocol version deprecated
  output logic rsp_type_depr, // Message type deprecated
  output logic rsp_bad, // Framing, length, tag or error-number fault
  output logic rx_pay_valid, // Pulse: payload byte out
  output logic [7:0] rx_pay_byte // Payload byte
);
  // ==========================================================
  // Transmit
  typedef enum logic [1:0] {T_IDLE, T_HDR, T_PAY, T_TAIL} tx_state_e;
  tx_state_e tst_r;
  logic [5:0] tidx_r;
  logic [31:0] tcnt_r;
  logic [31:0] ttype_r, ttag_r, tpay_r;
  logic [15:0] tflags_r;
  logic [7:0] tcs_r;
  logic [4:0] timm_len_r;
  logic [127:0] timm_r;
  logic [7:0] tx_data_r;
  logic tx_valid_r;
  logic [127:0] tcsum_r;

  wire cmd_bad = (cmd_imm_len > 5'(msg_codec_pkg::IMM_MAX))
              || (cmd_imm_len != 5'd0 && cmd_pay_len != 32'd0); // [R15] [R16]
  wire cmd_go = cmd_valid && cmd_ready && !cmd_bad;
  wire tx_step = !tx_valid_r || tx_ready;
  assign cmd_ready = (tst_r == T_IDLE);
  assign cmd_err = cmd_valid && cmd_ready && cmd_bad;
  wire [31:0] tremain = tpay_r + 32'(msg_codec_pkg::TAIL_LEN); // [R18]

  wire h_ver, h_flg, h_typ, h_tag, h_rem;
  wire [7:0] b_ver, b_flg, b_typ, b_tag, b_rem;
  byte_field #(.OFS(msg_codec_pkg::OFS_VER), .LEN(2)) f_ver (.idx(tidx_r),
    .value({16'h0, msg_codec_pkg::PROTO_VER_RST}), .hit(h_ver), .sel_byte(b_ver), .lane());
  byte_field #(.OFS(msg_codec_pkg::OFS_FLAGS), .LEN(2)) f_flg (.idx(tidx_r),
    .value({16'h0, tflags_r}), .hit(h_flg), .sel_byte(b_flg), .lane());
  byte_field #(.OFS(msg_codec_pkg::OFS_TYPE), .LEN(4)) f_typ (.idx(tidx_r),
    .value(ttype_r), .hit(h_typ), .sel_byte(b_typ), .lane()); // [R11]
  byte_field #(.OFS(msg_codec_pkg::OFS_TAG), .LEN(4)) f_tag (.idx(tidx_r),
    .value(ttag_r), .hit(h_tag), .sel_byte(b_tag), .lane()); // [R12]
  byte_field #(.OFS(msg_codec_pkg::OFS_REMAIN), .LEN(4)) f_rem (.idx(tidx_r),
    .value(tremain), .hit(h_rem), .sel_byte(b_rem), .lane()); // [R1] [R18]

  wire [3:0] imm_i = 4'(tidx_r - 6'(msg_codec_pkg::OFS_IMM));
  wire in_imm = tidx_r >= 6'(msg_codec_pkg::OFS_IMM) && tidx_r < 6'(msg_codec_pkg::OFS_REMAIN);
  wire [7:0] imm_b = (5'(imm_i) < timm_len_r) ? timm_r[8*imm_i +: 8] : 8'h00;
  // Error number and reserved bytes fall through to zero
  wire [7:0] hdr_b = (tidx_r == 6'(msg_codec_pkg::OFS_START)) ? msg_codec_pkg::START_B0 :
                     (tidx_r == 6'd1) ? msg_codec_pkg::START_B1 : // [R2]
                     h_ver ? b_ver : h_flg ? b_flg : h_typ ? b_typ : h_tag ? b_tag :
                     (tidx_r == 6'(msg_codec_pkg::OFS_CSUM_TYPE)) ? tcs_r : // [R13]
                     (tidx_r == 6'(msg_codec_pkg::OFS_IMM_LEN)) ? {3'h0, timm_len_r} :
                     in_imm ? imm_b : h_rem ? b_rem : 8'h00; // [R23]
  wire [4:0] tail_i = 5'(tcnt_r);
  wire [7:0] tail_b = (tail_i < 5'(msg_codec_pkg::CSUM_LEN)) ? tcsum_r[8*tail_i[3:0] +: 8] :
                      msg_codec_pkg::FOOTER[8*(5'd19 - tail_i) +: 8]; // [R3] [R14]
  assign pay_take = (tst_r == T_PAY) && tx_step;
  wire hdr_last = tidx_r == 6'(msg_codec_pkg::HDR_LEN - 1);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tst_r <= T_IDLE;
      tidx_r <= 6'h00;
      tcnt_r <= 32'h0;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
    end else begin
      case (tst_r)
        T_IDLE: begin
          if (tx_step) tx_valid_r <= 1'b0;
          if (cmd_go) begin
            tst_r <= T_HDR;
            tidx_r <= 6'h00;
          end
        end
        T_HDR: if (tx_step) begin
          tx_data_r <= hdr_b;
          tx_valid_r <= 1'b1;
          tidx_r <= tidx_r + 6'd1;
          tcnt_r <= 32'h0;
          if (hdr_last) tst_r <= (tpay_r == 32'h0) ? T_TAIL : T_PAY;
        end
        T_PAY: if (tx_step) begin
          tx_data_r <= pay_byte;
          tcnt_r <= tcnt_r + 32'd1;
          if (tcnt_r == tpay_r - 32'd1) begin
            tst_r <= T_TAIL;
            tcnt_r <= 32'h0;
          end
        end
        T_TAIL: if (tx_step) begin
          tx_data_r <= tail_b;
          tcnt_r <= tcnt_r + 32'd1;
          if (tcnt_r == 32'(msg_codec_pkg::TAIL_LEN - 1)) tst_r <= T_IDLE;
        end
        default: tst_r <= T_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ttype_r <= 32'h0;
      ttag_r <= 32'h0;
      tpay_r <= 32'h0;
      tflags_r <= 16'h0;
      tcs_r <= 8'h00;
      timm_len_r <= 5'h00;
      timm_r <= '0;
      tcsum_r <= '0;
    end else if (cmd_go) begin
      ttype_r <= cmd_type;
      ttag_r <= cmd_tag;
      tpay_r <= cmd_pay_len;
      tflags_r <= 16'(cmd_ack_req) << msg_codec_pkg::FLAG_ACK_REQ;
      tcs_r <= cmd_md5 ? msg_codec_pkg::CSUM_MD5 : msg_codec_pkg::CSUM_NONE;
      timm_len_r <= cmd_imm_len;
      timm_r <= cmd_imm;
      tcsum_r <= cmd_md5 ? csum_blk : '0; // [R13]
    end
  end
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;

  // ==========================================================
  // Receive: fixed header first, then exactly the announced count
  typedef enum logic [1:0] {R_HDR, R_PAY, R_TAIL} rx_state_e;
  rx_state_e rst_r;
  logic [5:0] ridx_r;
  logic [31:0] rcnt_r, rrem_r;
  logic [15:0] rflags_r, rerr_r;
  logic [31:0] rtype_r, rtag_r;
  logic [4:0] rimm_len_r;
  logic [127:0] rimm_r;
  logic rbad_r, done_r, pv_r;
  logic [7:0] pb_r;
  assign rx_ready = 1'b1;
  wire rx_go = rx_valid;
  wire [31:0] rpay = rrem_r - 32'(msg_codec_pkg::TAIL_LEN); // [R19]
  wire [1:0] rl = ridx_r[1:0];
  wire [4:0] rtail = 5'(rcnt_r);
  wire [7:0] foot_exp = msg_codec_pkg::FOOTER[8*(5'd19 - rtail) +: 8];
  wire hdr_fault = (ridx_r == 6'd0 && rx_data != msg_codec_pkg::START_B0)
                || (ridx_r == 6'd1 && rx_data != msg_codec_pkg::START_B1)
                || (ridx_r == 6'(msg_codec_pkg::OFS_IMM_LEN)
                    && rx_data > 8'(msg_codec_pkg::IMM_MAX)); // [R2] [R15]
  // Error number without NACK or exception is a device fault
  wire err_fault = (rerr_r != 16'h0) && !rflags_r[msg_codec_pkg::FLAG_NACK]
                && !rflags_r[msg_codec_pkg::FLAG_EXC]; // [R7]
  // Four-bit wrap keeps the immediate lane inside the block for bytes 32 to 39
  wire [3:0] rimm_i = ridx_r[3:0] - 4'h8;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rst_r <= R_HDR;
      ridx_r <= 6'h00;
      rcnt_r <= 32'h0;
      rrem_r <= 32'h0;
      rflags_r <= 16'h0;
      rerr_r <= 16'h0;
      rtype_r <= 32'h0;
      rtag_r <= 32'h0;
      rimm_len_r <= 5'h00;
      rimm_r <= '0;
      rbad_r <= 1'b0;
      done_r <= 1'b0;
      pv_r <= 1'b0;
      pb_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      pv_r <= 1'b0;
      if (rx_go) begin
        case (rst_r)
          R_HDR: begin
            if (ridx_r == 6'd0) rbad_r <= hdr_fault;
            else if (hdr_fault) rbad_r <= 1'b1;
            if (ridx_r == 6'(msg_codec_pkg::OFS_FLAGS) + 6'(rl[0]))
              rflags_r[8*rl[0] +: 8] <= rx_data; // [R1]
            if (ridx_r[5:1] == 5'(msg_codec_pkg::OFS_ERR >> 1)) rerr_r[8*rl[0] +: 8] <= rx_data;
            if (ridx_r[5:2] == 4'(msg_codec_pkg::OFS_TYPE >> 2)) rtype_r[8*rl +: 8] <= rx_data;
            if (ridx_r[5:2] == 4'(msg_codec_pkg::OFS_TAG >> 2)) rtag_r[8*rl +: 8] <= rx_data;
            if (ridx_r == 6'(msg_codec_pkg::OFS_IMM_LEN)) rimm_len_r <= rx_data[4:0];
            if (ridx_r >= 6'(msg_codec_pkg::OFS_IMM) && ridx_r < 6'(msg_codec_pkg::OFS_REMAIN))
              rimm_r[8*rimm_i +: 8] <= rx_data;
            if (ridx_r[5:2] == 4'(msg_codec_pkg::OFS_REMAIN >> 2)) rrem_r[8*rl +: 8] <= rx_data;
            ridx_r <= ridx_r + 6'd1;
            if (ridx_r == 6'(msg_codec_pkg::HDR_LEN - 1)) begin
              ridx_r <= 6'h00;
              rcnt_r <= 32'h0;
              rst_r <= ({rx_data, rrem_r[23:0]} > 32'(msg_codec_pkg::TAIL_LEN)) ? R_PAY : R_TAIL; // [R20]
              if ({rx_data, rrem_r[23:0]} < 32'(msg_codec_pkg::TAIL_LEN)) rbad_r <= 1'b1; // [R18]
            end
          end
          R_PAY: begin
            pv_r <= 1'b1;
            pb_r <= rx_data; // [R22]
            rcnt_r <= rcnt_r + 32'd1;
            if (rcnt_r == rpay - 32'd1) begin
              rst_r <= R_TAIL;
              rcnt_r <= 32'h0;
            end
          end
          R_TAIL: begin
            if (rtail >= 5'(msg_codec_pkg::CSUM_LEN) && rx_data != foot_exp) rbad_r <= 1'b1; // [R3]
            rcnt_r <= rcnt_r + 32'd1;
            if (rcnt_r == 32'(msg_codec_pkg::TAIL_LEN - 1)) begin
              rst_r <= R_HDR;
              done_r <= 1'b1;
              if (rtag_r != ttag_r || err_fault) rbad_r <= 1'b1; // [R12] [R7]
            end
          end
          default: rst_r <= R_HDR;
        endcase
      end
    end
  end

  assign rsp_done = done_r;
  assign rsp_flags = rflags_r;
  assign rsp_err = rerr_r; // [R8] [R9] [R10]
  assign rsp_type = rtype_r; // [R4]
  assign rsp_tag = rtag_r;
  assign rsp_pay_len = rpay;
  assign rsp_imm_len = rimm_len_r;
  assign rsp_imm = (rpay != 32'h0) ? '0 : rimm_r; // [R17]
  assign rsp_nack = rflags_r[msg_codec_pkg::FLAG_NACK]; // [R4] [R21]
  assign rsp_exc = rflags_r[msg_codec_pkg::FLAG_EXC];
  assign rsp_ver_depr = rflags_r[msg_codec_pkg::FLAG_VER_DEPR]; // [R5]
  assign rsp_type_depr = rflags_r[msg_codec_pkg::FLAG_TYPE_DEPR]; // [R6]
  assign rsp_bad = rbad_r;
  assign rx_pay_valid = pv_r;
  assign rx_pay_byte = pb_r;

  // ==========================================================
  // Checks
  start_first_a: assert property (@(posedge core_clk) disable iff (rst) // [R2]
    (tst_r == T_IDLE && cmd_go) |=> ##1 (tx_data == msg_codec_pkg::START_B0))
    else $error("first byte not start pattern");
  imm_guard_a: assert property (@(posedge core_clk) disable iff (rst) // [R15]
    cmd_valid && cmd_ready && cmd_imm_len > 5'(msg_codec_pkg::IMM_MAX) |->
      cmd_err ##1 tst_r == T_IDLE)
    else $error("immediate length above sixteen accepted");
  imm_nopay_a: assert property (@(posedge core_clk) disable iff (rst) // [R16]
    cmd_valid && cmd_ready && cmd_imm_len != 5'd0 && cmd_pay_len != 32'd0 |->
      cmd_err ##1 tst_r == T_IDLE)
    else $error("immediate and payload together");
  tag_kept_a: assert property (@(posedge core_clk) disable iff (rst) // [R12]
    cmd_go |=> ttag_r == $past(cmd_tag))
    else $error("tag not latched");
  remain_sum_a: assert property (@(posedge core_clk) disable iff (rst) // [R18]
    tst_r == T_HDR && tx_step && tidx_r == 6'(msg_codec_pkg::OFS_REMAIN) |=>
      tx_data == 8'(tpay_r + 32'(msg_codec_pkg::TAIL_LEN)))
    else $error("bytes remaining low byte wrong");
  pay_derive_a: assert property (@(posedge core_clk) disable iff (rst) // [R19]
    rst_r == R_PAY |-> rcnt_r < rsp_pay_len)
    else $error("payload count ran past derived length");
  imm_ignore_a: assert property (@(posedge core_clk) disable iff (rst) // [R17]
    rx_pay_valid |-> rsp_imm == '0)
    else $error("immediate shown with payload");
  csum_zero_a: assert property (@(posedge core_clk) disable iff (rst) // [R13]
    cmd_go && !cmd_md5 |=> tcsum_r == '0 && tcs_r == 8'h00)
    else $error("checksum block not zero for none");
endmodule : msg_host_codec

// ---- tb/msg_dev_model.sv ----
// Behavioural device that answers the host codec over the two byte streams
`timescale 1ns/1ns
module msg_dev_model (
  input wire logic core_clk, // System clock
  input wire logic tx_valid, // Host byte valid
  input wire logic [7:0] tx_data, // Host byte
  output logic tx_ready, // Host byte taken
  output logic rx_valid, // Reply byte valid
  output logic [7:0] rx_data, // Reply byte
  input wire logic slow, // Stall both directions at random
  input wire logic [15:0] cfg_flags, // Reply flags
  input wire logic [15:0] cfg_err, // Reply error number
  input wire logic [7:0] cfg_pay, // Reply payload length
  input wire logic [31:0] cfg_xor // Tag corruption mask
);
  logic [7:0] got[$];
  logic [7:0] last_msg[$];
  logic [7:0] q[$];
  logic [31:0] rem;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  // =======================================================
  // Framing: header first, then exactly the announced rest
  initial forever begin
    @(negedge core_clk);
    tx_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
    if (got.size() >= 44) begin
      rem = {got[43], got[42], got[41], got[40]};
      if (got.size() == 44 + rem) begin
        last_msg = got;
        got = {};
        reply();
      end
    end
  end
  task automatic reply();
    logic [7:0] ilen;
    ilen = (cfg_pay == 8'h00) ? 8'h0c : 8'h00;
    q = {8'hc1, 8'hc0, 8'h00, 8'h11, cfg_flags[7:0], cfg_flags[15:8]};
    q = {q, cfg_err[7:0], cfg_err[15:8]};
    for (int k = 8; k < 12; k++) q.push_back(last_msg[k]);
    for (int k = 12; k < 16; k++) q.push_back(last_msg[k] ^ cfg_xor[8*(k-12) +: 8]);
    repeat (6) q.push_back(8'h00);
    q = {q, 8'h00, ilen};
    // Garbage in the immediate area when a payload follows, which must be ignored
    for (int k = 0; k < 16; k++) begin
      q.push_back((k < ilen) ? 8'(8'h30 + k) : ((cfg_pay != 0) ? 8'hee : 8'h00));
    end
    for (int k = 0; k < 4; k++) q.push_back(8'((32'(cfg_pay) + 20) >> (8*k)));
    for (int k = 0; k < cfg_pay; k++) q.push_back(8'(8'h80 + k));
    repeat (16) q.push_back(8'h00);
    q = {q, 8'hc5, 8'hc4, 8'hc3, 8'hc2};
    foreach (q[k]) begin
      if (slow && $urandom_range(1, 0)) begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        @(negedge core_clk);
      end
      rx_valid <= 1'b1;
      rx_data <= q[k];
      @(negedge core_clk);
    end
    // Released line shows the inverse, never a stale byte
    rx_valid <= 1'b0;
    rx_data <= ~q[q.size()-1];
  endtask : reply
endmodule : msg_dev_model

// ---- tb/msg_host_codec_test.sv ----
// Self-checking bench of the host message codec against the device model
`timescale 1ns/1ns
module msg_host_codec_test;
  typedef struct {
    logic [15:0] flags;
    logic [15:0] err;
    logic [31:0] typ;
    logic [31:0] tag;
    logic [31:0] plen;
    logic [4:0] ilen;
    logic [127:0] imm;
    logic bad;
  } note_s;
  logic core_clk, rst, cmd_valid, cmd_ready, cmd_ack_req, cmd_md5, pay_take, cmd_err;
  logic tx_valid, tx_ready, rx_valid, rx_ready, rsp_done, rsp_nack, rsp_exc, slow;
  logic rsp_ver_depr, rsp_type_depr, rsp_bad, rx_pay_valid;
  logic [31:0] cmd_type, cmd_tag, cmd_pay_len, rsp_type, rsp_tag, rsp_pay_len, cfg_xor;
  logic [4:0] cmd_imm_len, rsp_imm_len;
  logic [127:0] cmd_imm, csum_blk, rsp_imm;
  logic [7:0] pay_byte, tx_data, rx_data, rx_pay_byte, cfg_pay, pay_idx;
  logic [15:0] rsp_flags, rsp_err, cfg_flags, cfg_err;
  int err_total = 0;
  int cmp_count = 0;
  note_s notes[$];
  note_s nt;
  logic [7:0] pay_q[$];
  msg_host_codec u_msg_host_codec (.core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_type,
    .cmd_tag, .cmd_ack_req, .cmd_md5, .cmd_imm_len, .cmd_imm, .cmd_pay_len, .pay_byte,
    .pay_take, .csum_blk, .cmd_err, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready,
    .rx_data, .rsp_done, .rsp_flags, .rsp_err, .rsp_type, .rsp_tag, .rsp_pay_len,
    .rsp_imm_len, .rsp_imm, .rsp_nack, .rsp_exc, .rsp_ver_depr, .rsp_type_depr, .rsp_bad,
    .rx_pay_valid, .rx_pay_byte);
  msg_dev_model u_msg_dev_model (.core_clk, .tx_valid, .tx_data, .tx_ready, .rx_valid,
    .rx_data, .slow, .cfg_flags, .cfg_err, .cfg_pay, .cfg_xor);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  assign pay_byte = 8'h50 + pay_idx;
  always @(posedge core_clk) begin
    if (pay_take === 1'b1) pay_idx <= pay_idx + 8'h01;
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // =======================================================
  // One command and its reply, then the wire image of the command
  task automatic run(input int r);
    logic [31:0] typ, tag, plen;
    logic [4:0] ilen;
    logic [127:0] imm, cs;
    logic [351:0] hdr;
    logic [7:0] e;
    logic md5, ack;
    int n, w;
    typ = $urandom();
    tag = $urandom();
    md5 = r[0];
    ack = r[1];
    plen = (r % 3 == 1) ? 32'(r + 1) : 32'h0;
    ilen = (plen != 0) ? 5'h00 : ((r == 2) ? 5'h10 : 5'(r % 5));
    imm = {$urandom(), $urandom(), $urandom(), $urandom()};
    cs = {$urandom(), $urandom(), $urandom(), $urandom()};
    for (int k = 0; k < 16; k++) if (k >= ilen) imm[8*k +: 8] = 8'h00;
    @(negedge core_clk);
    slow = r[2];
    cfg_pay = (r % 4 == 3) ? 8'(r) : 8'h00;
    cfg_xor = (r == 5) ? 32'h00000100 : 32'h0;
    cfg_err = (r >= 8) ? 16'(r - 7) : 16'h0000;
    cfg_flags = {9'h000, r == 1, r == 1, r == 4, r >= 7, 1'b0, ack, 1'b1};
    if (r == 4) cfg_err = 16'h0009;
    if (r == 6) cfg_err = 16'h0003;
    if (r == 7) cfg_err = msg_codec_pkg::ERR_FW_DECRYPT;
    notes.push_back('{cfg_flags, cfg_err, typ, tag ^ cfg_xor, 32'(cfg_pay),
      (cfg_pay == 0) ? 5'h0c : 5'h00,
      (cfg_pay == 0) ? 128'h3b3a3938_37363534_33323130 : 128'h0,
      (cfg_xor != 0) || (r == 6)});
    for (int k = 0; k < cfg_pay; k++) pay_q.push_back(8'(8'h80 + k));
    w = 0;
    while (cmd_ready !== 1'b1 && w < 200) begin
      @(negedge core_clk);
      w++;
    end
    if (w >= 200) err_total++;
    {cmd_type, cmd_tag, cmd_md5, cmd_ack_req} = {typ, tag, md5, ack};
    {cmd_imm_len, cmd_imm, cmd_pay_len, csum_blk} = {ilen, imm, plen, cs};
    pay_idx = 8'h00;
    cmd_valid = 1'b1;
    #5;
    check(cmd_err, 1'b0);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    w = 0;
    while (notes.size() != 0 && w < 3000) begin
      @(negedge core_clk);
      w++;
    end
    if (w >= 3000) err_total++;
    hdr = {32'(plen + 20), imm, 3'b000, ilen, 7'h00, md5, 48'h0, tag, typ, 16'h0000,
      13'h0, ack, 2'b00, 16'h1100, 8'hc0, 8'hc1};
    n = 44 + plen + 20;
    check(128'(u_msg_dev_model.last_msg.size()), 128'(n));
    for (int k = 0; k < n && k < u_msg_dev_model.last_msg.size(); k++) begin
      e = (k < 44) ? hdr[8*k +: 8] : (k < 44 + plen) ? 8'(8'h50 + k - 44) :
        (k < n - 4) ? (md5 ? cs[8*(k-44-plen) +: 8] : 8'h00) : 8'(32'hc2c3c4c5 >> (8*(k-n+4)));
      check(u_msg_dev_model.last_msg[k], e);
    end
    $display("test %0d done", r);
  endtask : run
  // Malformed request: flagged, nothing reaches the link
  task automatic refuse(input logic [4:0] ilen, input logic [31:0] plen);
    @(negedge core_clk);
    cmd_imm_len = ilen;
    cmd_pay_len = plen;
    cmd_valid = 1'b1;
    #5;
    check(cmd_err, 1'b1);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    repeat (4) @(negedge core_clk);
    check({tx_valid, cmd_ready, rx_ready, 8'(u_msg_dev_model.got.size())}, 11'h300);
    $display("refusal test done");
  endtask : refuse
  // =======================================================
  // Response watcher, oldest note first
  always @(negedge core_clk) begin
    if (rx_pay_valid === 1'b1) check(rx_pay_byte, pay_q.pop_front());
    if (rsp_done === 1'b1) begin
      nt = notes.pop_front();
      check(rsp_flags, nt.flags);
      check(rsp_err, nt.err);
      check(rsp_type, nt.typ);
      check(rsp_tag, nt.tag);
      check(rsp_pay_len, nt.plen);
      check(rsp_imm_len, nt.ilen);
      check(rsp_imm, nt.imm);
      check({rsp_type_depr, rsp_ver_depr, rsp_exc, rsp_nack}, nt.flags[6:3]);
      check(rsp_bad, nt.bad);
    end
  end
  initial begin
    {rst, cmd_valid, cmd_ack_req, cmd_md5, slow, pay_idx} = {1'b1, 4'h0, 8'h00};
    {cmd_type, cmd_tag, cmd_pay_len, cmd_imm_len, cmd_imm, csum_blk} = '0;
    {cfg_flags, cfg_err, cfg_pay, cfg_xor} = '0;
    void'($urandom(89786));
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    for (int r = 0; r < 21; r++) run(r);
    refuse(5'h11, 32'h0);
    refuse(5'h03, 32'h5);
    summarize();
  end
  // Whole run is some 4000 cycles; fifteen times that means a hang
  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    summarize();
  end
endmodule : msg_host_codec_test
